/* File: core/pwc_capture_map.svh */
/*
 * Constant map of the pulse width and cascade capture timer block:
 * mode codes, edge field codes and positions, counter limits.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef PWC_CAPTURE_MAP_SVH
`define PWC_CAPTURE_MAP_SVH

// operating mode field codes
`define PWC_MODE_FREE_RUN 3'h5
`define PWC_MODE_PULSE_WIDTH 3'h6

// edge field codes
`define PWC_EDGE_NONE 2'h0
`define PWC_EDGE_RISE 2'h1
`define PWC_EDGE_FALL 2'h2
`define PWC_EDGE_BOTH 2'h3

// edge field positions inside the four-bit edge select
`define PWC_EDGE0_LSB 0
`define PWC_EDGE1_LSB 2

// counter limits and reset values
`define PWC_COUNT_ZERO 16'h0000
`define PWC_COUNT_MAX 16'hffff
`define PWC_CAPTURE_RESET 16'h0000

// count clock prescaler: select code n gives one tick every 2**n cycles
`define PWC_PRESCALE_MAX_SEL 3'h7

`endif

/* File: core/pwc_pkg.sv */
/*
 * Types shared by the pulse width and cascade capture timer block.
 * Assumes pwc_capture_map.svh is on the include path.
 */
`include "pwc_capture_map.svh"

package pwc_pkg;

    // operating modes that this block serves
    typedef enum logic [2:0] {
        PWC_MODE_FREE_RUN = 3'b101,
        PWC_MODE_PULSE_WIDTH = 3'b110
    } pwc_mode_t;

    // per-input edge detection choice
    typedef enum logic [1:0] {
        PWC_EDGE_NONE = 2'b00,
        PWC_EDGE_RISE = 2'b01,
        PWC_EDGE_FALL = 2'b10,
        PWC_EDGE_BOTH = 2'b11
    } pwc_edge_t;

    // decode an edge field against the previous and present pin level
    function automatic logic pwc_edge_hit(input logic [1:0] field, input logic prev,
                                          input logic cur);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        case (field)
            `PWC_EDGE_RISE: pwc_edge_hit = rise;
            `PWC_EDGE_FALL: pwc_edge_hit = fall;
            `PWC_EDGE_BOTH: pwc_edge_hit = rise | fall;
            default: pwc_edge_hit = 1'b0;
        endcase
    endfunction

endpackage

/* File: core/pwc_edge_detect.sv */
/*
 * Edge detector for one capture input, decoded by its two-bit edge field.
 * Assumes the pin is synchronous to clock_in.
 */
`timescale 1ns/1ps

module pwc_edge_detect (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // pin and edge choice
    input wire logic pin_in,
    input wire logic [1:0] edge_field_in,
    // one-cycle edge pulse
    output logic edge_out
);

    logic prev_q;

    // previous pin level
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin_in;
        end
    end

    // [R4] edge field decode
    always_comb begin
        edge_out = pwc_pkg::pwc_edge_hit(edge_field_in, prev_q, pin_in);
    end

endmodule

/* File: core/pwc_prescaler.sv */
/*
 * Count clock prescaler: one-cycle tick every 2**select cycles.
 * Assumes select is changed only while the unit is stopped.
 */
`timescale 1ns/1ps

module pwc_prescaler #(
    parameter int DIV_WIDTH = 8
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // divider choice
    input wire logic [2:0] select_in,
    // count clock tick
    output logic tick_out
);

    logic [DIV_WIDTH-1:0] div_q;
    logic [DIV_WIDTH-1:0] mask;

    initial begin
        if (DIV_WIDTH < 8) begin
            $error("pwc_prescaler: DIV_WIDTH must be at least 8");
        end
    end

    // low bits that must all be set for a tick
    always_comb begin
        mask = DIV_WIDTH'((1 << select_in) - 1);
    end

    // free-running divider and registered tick
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_q <= '0;
            tick_out <= 1'b0;
        end else begin
            div_q <= div_q + 1'b1;
            tick_out <= ((div_q & mask) == mask);
        end
    end

endmodule

/* File: core/pwc_capture_top.sv */
/*
 * Group of 16-bit capture timer units with pulse width measurement and
 * 32-bit cascaded capture of even/odd unit pairs.
 * Assumes control inputs come from a register file elsewhere and that all
 * inputs are synchronous to clock_in.
 */
// Operation
// [R1] mode 110B: free count; input edge copies counter to its register, clears counter
// [R2] software keeps external event select at 0 in pulse width mode
// [R3] period measurement: one input rising or falling, the other off
// [R4] edge field 00 none, 01 rise, 10 fall, 11 both; bits 1:0 and 3:2
// [R5] one input on both edges captures every edge, clears counter each time
// [R6] past FFFFH the next count clock sets overflow, clears counter, keeps counting
// [R7] overflow flag stays set until software clears it
// [R8] opposite edges on both inputs capture into their own registers and clear
// [R9] units 0 with 1 and 2 with 3 cascade; lower unit is master
// [R10] the unpaired last unit offers no cascade
// [R11] software cascades only in free-running mode with both registers capturing
// [R12] software sets slave cascade select 1, master 0, slave configured first
// [R13] in cascade only the master inputs trigger the 32-bit capture
// [R14] master count enable starts cascade; master low half, slave high half
// [R15] master overflow clears it, signals, bumps slave; slave overflow clears, signals
// [R16] master trigger captures both halves in one cycle, master capture interrupt
// [R17] software reads halves with a pending-flag check sequence
// [R18] counter halves readable separately while counting continues
// [R19] capture before first count clock after start may read FFFFH
// [R20] count enable starts upward count from 0000H until cleared
// [R21] clearing count enable stops counter, keeps captured values
`timescale 1ns/1ps

module pwc_capture_top #(
    parameter int NUM_UNITS = 5,
    parameter int DIV_WIDTH = 8
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // per-unit control
    input wire logic [NUM_UNITS-1:0] count_enable_bit_in,
    input wire logic [NUM_UNITS-1:0][2:0] operating_mode_field_in,
    input wire logic [NUM_UNITS-1:0][2:0] clock_select_in,
    input wire logic [NUM_UNITS-1:0][1:0] capture_select_in,
    input wire logic [NUM_UNITS-1:0][3:0] edge_select_in,
    input wire logic [NUM_UNITS-1:0] cascade_slave_select_in,
    input wire logic [NUM_UNITS-1:0] overflow_clear_in,
    // capture pins
    input wire logic [NUM_UNITS-1:0] capture_input_zero_in,
    input wire logic [NUM_UNITS-1:0] capture_input_one_in,
    // per-unit state
    output logic [NUM_UNITS-1:0][15:0] counter_value_out,
    output logic [NUM_UNITS-1:0][15:0] capture_register_zero_out,
    output logic [NUM_UNITS-1:0][15:0] capture_register_one_out,
    output logic [NUM_UNITS-1:0] overflow_flag_out,
    // per-unit event pulses
    output logic [NUM_UNITS-1:0] overflow_interrupt_out,
    output logic [NUM_UNITS-1:0] capture_interrupt_zero_out,
    output logic [NUM_UNITS-1:0] capture_interrupt_one_out
);

    // cross-unit wiring
    logic [NUM_UNITS-1:0] tick;
    logic [NUM_UNITS-1:0] edge0;
    logic [NUM_UNITS-1:0] edge1;
    logic [NUM_UNITS-1:0] is_master;
    logic [NUM_UNITS-1:0] is_slave;
    logic [NUM_UNITS-1:0] run;
    logic [NUM_UNITS-1:0] step;
    logic [NUM_UNITS-1:0] ovf_evt;
    logic [NUM_UNITS-1:0] cap0;
    logic [NUM_UNITS-1:0] cap1;
    logic [NUM_UNITS-1:0] own_cap0;
    logic [NUM_UNITS-1:0] own_cap1;
    logic [NUM_UNITS-1:0] clr;

    // refuse unit counts the pairing cannot serve
    initial begin
        if (NUM_UNITS < 1 || NUM_UNITS > 16) begin
            $error("pwc_capture_top: NUM_UNITS must be 1 to 16");
        end
        if (DIV_WIDTH < 8) begin
            $error("pwc_capture_top: DIV_WIDTH must be at least 8");
        end
    end

    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u = u + 1) begin : g_unit
            logic [15:0] cnt_q;
            logic [15:0] cap0_q;
            logic [15:0] cap1_q;
            logic run_q;
            logic first_q;
            logic ovf_flag_q;
            logic ovf_irq_q;
            logic cc0_irq_q;
            logic cc1_irq_q;
            logic [2:0] mode;
            logic [1:0] ccs;
            logic cap_ok0;
            logic cap_ok1;
            logic at_max;

            // count clock for this unit
            pwc_prescaler #(
                .DIV_WIDTH(DIV_WIDTH)
            ) u_prescaler (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .select_in(clock_select_in[u]),
                .tick_out(tick[u])
            );

            // [R4] input zero edge decode
            pwc_edge_detect u_edge0 (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .pin_in(capture_input_zero_in[u]),
                .edge_field_in(edge_select_in[u][`PWC_EDGE0_LSB +: 2]),
                .edge_out(edge0[u])
            );

            // [R4] input one edge decode
            pwc_edge_detect u_edge1 (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .pin_in(capture_input_one_in[u]),
                .edge_field_in(edge_select_in[u][`PWC_EDGE1_LSB +: 2]),
                .edge_out(edge1[u])
            );

            // [R9] [R10] pair roles: even master with an odd partner only
            if ((u % 2 == 0) && (u + 1 < NUM_UNITS)) begin : g_master
                assign is_master[u] = cascade_slave_select_in[u + 1]
                                      & ~cascade_slave_select_in[u];
                assign is_slave[u] = 1'b0;
            end else if (u % 2 == 1) begin : g_slave
                assign is_master[u] = 1'b0;
                assign is_slave[u] = cascade_slave_select_in[u]
                                     & ~cascade_slave_select_in[u - 1];
            end else begin : g_single
                assign is_master[u] = 1'b0;
                assign is_slave[u] = 1'b0;
            end

            assign mode = operating_mode_field_in[u];
            assign ccs = capture_select_in[u];
            assign at_max = (cnt_q == `PWC_COUNT_MAX);

            // which registers capture in the selected mode
            always_comb begin
                cap_ok0 = (mode == `PWC_MODE_PULSE_WIDTH)
                          | ((mode == `PWC_MODE_FREE_RUN) & ccs[0]);
                cap_ok1 = (mode == `PWC_MODE_PULSE_WIDTH)
                          | ((mode == `PWC_MODE_FREE_RUN) & ccs[1]);
                own_cap0[u] = run[u] & edge0[u] & cap_ok0;
                own_cap1[u] = run[u] & edge1[u] & cap_ok1;
            end

            if (u % 2 == 1) begin : g_cascade
                // [R14] slave runs on the master's enable
                assign run[u] = is_slave[u] ? count_enable_bit_in[u - 1]
                                            : count_enable_bit_in[u];
                // [R15] slave steps on master overflow
                assign step[u] = is_slave[u] ? ovf_evt[u - 1] : (run[u] & tick[u]);
                // [R13] [R16] slave follows only the master triggers
                assign cap0[u] = is_slave[u] ? cap0[u - 1] : own_cap0[u];
                assign cap1[u] = is_slave[u] ? cap1[u - 1] : own_cap1[u];
            end else begin : g_plain
                assign run[u] = count_enable_bit_in[u];
                assign step[u] = run[u] & tick[u];
                assign cap0[u] = own_cap0[u];
                assign cap1[u] = own_cap1[u];
            end

            // [R1] [R3] [R5] [R8] pulse width mode clears on capture
            assign clr[u] = ~is_slave[u] & (mode == `PWC_MODE_PULSE_WIDTH)
                            & (own_cap0[u] | own_cap1[u]);

            // [R6] [R15] overflow on a step from FFFFH
            assign ovf_evt[u] = run[u] & run_q & step[u] & at_max & ~first_q & ~clr[u];

            // enable history for start detection
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    run_q <= 1'b0;
                end else begin
                    run_q <= run[u];
                end
            end

            // counter
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    cnt_q <= `PWC_COUNT_ZERO;
                    first_q <= 1'b0;
                end else if (run[u] && !run_q) begin
                    // [R19] [R20] preset so the first count clock lands on 0000H
                    // [R15] a cascaded slave starts at 0000H so its first bump gives 0001H
                    cnt_q <= is_slave[u] ? `PWC_COUNT_ZERO : `PWC_COUNT_MAX;
                    first_q <= ~is_slave[u];
                end else if (run[u]) begin
                    if (clr[u]) begin
                        // [R1] clear on capture
                        cnt_q <= `PWC_COUNT_ZERO;
                        first_q <= 1'b0;
                    end else if (step[u] && first_q) begin
                        // [R20] first count clock
                        cnt_q <= `PWC_COUNT_ZERO;
                        first_q <= 1'b0;
                    end else if (step[u]) begin
                        // [R6] [R15] wraps to 0000H and keeps counting
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
            end

            // [R1] [R16] [R21] capture registers hold when idle
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    cap0_q <= `PWC_CAPTURE_RESET;
                    cap1_q <= `PWC_CAPTURE_RESET;
                end else begin
                    if (cap0[u]) begin
                        cap0_q <= cnt_q;
                    end
                    if (cap1[u]) begin
                        cap1_q <= cnt_q;
                    end
                end
            end

            // [R7] sticky overflow flag, set wins over clear
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    ovf_flag_q <= 1'b0;
                end else if (ovf_evt[u]) begin
                    ovf_flag_q <= 1'b1;
                end else if (overflow_clear_in[u]) begin
                    ovf_flag_q <= 1'b0;
                end
            end

            // [R6] [R15] [R16] interrupt pulses; slave captures do not signal
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    ovf_irq_q <= 1'b0;
                    cc0_irq_q <= 1'b0;
                    cc1_irq_q <= 1'b0;
                end else begin
                    ovf_irq_q <= ovf_evt[u];
                    cc0_irq_q <= cap0[u] & ~is_slave[u];
                    cc1_irq_q <= cap1[u] & ~is_slave[u];
                end
            end

            // [R18] counter halves visible at all times
            assign counter_value_out[u] = cnt_q;
            assign capture_register_zero_out[u] = cap0_q;
            assign capture_register_one_out[u] = cap1_q;
            assign overflow_flag_out[u] = ovf_flag_q;
            assign overflow_interrupt_out[u] = ovf_irq_q;
            assign capture_interrupt_zero_out[u] = cc0_irq_q;
            assign capture_interrupt_one_out[u] = cc1_irq_q;
        end
    endgenerate

endmodule

/* File: verif/pwc_capture_props.sv */
/* Concurrent checks on units 0 and 1 of the capture timer group.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps

module pwc_capture_props #(
    parameter int NUM_UNITS = 5
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // control
    input wire logic [NUM_UNITS-1:0] count_enable_bit_in,
    input wire logic [NUM_UNITS-1:0][2:0] operating_mode_field_in,
    input wire logic [NUM_UNITS-1:0] cascade_slave_select_in,
    input wire logic [NUM_UNITS-1:0] overflow_clear_in,
    // state and events
    input wire logic [NUM_UNITS-1:0][15:0] counter_value_out,
    input wire logic [NUM_UNITS-1:0][15:0] capture_register_zero_out,
    input wire logic [NUM_UNITS-1:0][15:0] capture_register_one_out,
    input wire logic [NUM_UNITS-1:0] overflow_flag_out,
    input wire logic [NUM_UNITS-1:0] overflow_interrupt_out,
    input wire logic [NUM_UNITS-1:0] capture_interrupt_zero_out,
    input wire logic [NUM_UNITS-1:0] capture_interrupt_one_out
);
    logic casc;

    // units 0 and 1 joined as one wide capture timer
    assign casc = cascade_slave_select_in[1] & ~cascade_slave_select_in[0];

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_ovf_wraps: assert property (
        overflow_interrupt_out[0] |-> overflow_flag_out[0] && counter_value_out[0] == 16'h0000
            && $past(counter_value_out[0]) == 16'hffff) else $error("overflow without wrap");
    a_ovf_pulse: assert property (
        overflow_interrupt_out[0] |=> !overflow_interrupt_out[0]) else $error("overflow pulse long");
    a_flag_sticky: assert property (
        $fell(overflow_flag_out[0]) |-> $past(overflow_clear_in[0]))
        else $error("flag dropped on its own");
    a_cap0_value: assert property (
        capture_interrupt_zero_out[0] |-> capture_register_zero_out[0] == $past(counter_value_out[0]))
        else $error("capture zero value wrong");
    a_cap1_value: assert property (
        capture_interrupt_one_out[0] |-> capture_register_one_out[0] == $past(counter_value_out[0]))
        else $error("capture one value wrong");
    a_pw_clear: assert property (
        (capture_interrupt_zero_out[0] || capture_interrupt_one_out[0])
            && $past(operating_mode_field_in[0]) == 3'h6 |-> counter_value_out[0] == 16'h0000)
        else $error("counter not cleared on capture");
    a_stop_holds: assert property (
        $past(!count_enable_bit_in[0]) && !$past(cascade_slave_select_in[0])
            |-> $stable(counter_value_out[0]) && !capture_interrupt_zero_out[0]
            && !overflow_interrupt_out[0]) else $error("stopped unit changed");
    a_casc_high: assert property (
        casc && capture_interrupt_zero_out[0]
            |-> capture_register_zero_out[1] == $past(counter_value_out[1]))
        else $error("upper half not captured");
    a_slave_bump: assert property (
        casc && overflow_interrupt_out[0]
            |-> counter_value_out[1] == 16'($past(counter_value_out[1]) + 16'h0001))
        else $error("upper half not bumped");
    a_slave_quiet: assert property (
        casc |-> !capture_interrupt_zero_out[1] && !capture_interrupt_one_out[1])
        else $error("slave captured on its own");
endmodule

bind pwc_capture_top pwc_capture_props #(.NUM_UNITS(NUM_UNITS)) u_props (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .count_enable_bit_in(count_enable_bit_in),
    .operating_mode_field_in(operating_mode_field_in),
    .cascade_slave_select_in(cascade_slave_select_in),
    .overflow_clear_in(overflow_clear_in),
    .counter_value_out(counter_value_out),
    .capture_register_zero_out(capture_register_zero_out),
    .capture_register_one_out(capture_register_one_out),
    .overflow_flag_out(overflow_flag_out),
    .overflow_interrupt_out(overflow_interrupt_out),
    .capture_interrupt_zero_out(capture_interrupt_zero_out),
    .capture_interrupt_one_out(capture_interrupt_one_out)
);

/* File: verif/pwc_pulse_src.sv */
/* External pulse source: bursts of high/low periods on one pin.
   Assumes requests change just after a rising clock edge. */
`timescale 1ns/1ps

module pwc_pulse_src (
    // clock
    input wire logic clock_in,
    // burst request
    input wire logic go_in,
    input wire logic [7:0] high_len_in,
    input wire logic [7:0] low_len_in,
    input wire logic [3:0] periods_in,
    // pin and status
    output logic pin_out,
    output logic busy_out
);
    initial begin
        pin_out = 1'b0;
        busy_out = 1'b0;
    end

    // steady high and low spans, idle low between bursts
    always @(posedge clock_in) begin
        if (go_in && !busy_out) begin
            busy_out = 1'b1;
            repeat (periods_in) begin
                #1 pin_out = 1'b1;
                repeat (high_len_in) @(posedge clock_in);
                #1 pin_out = 1'b0;
                repeat (low_len_in) @(posedge clock_in);
            end
            busy_out = 1'b0;
        end
    end
endmodule

/* File: verif/tb_top.sv */
/* Self-checking bench for the capture timer group.
   Assumes the pulse source and the bound checker are compiled first. */
`timescale 1ns/1ps

module tb_top;
    localparam int N = 5;
    logic clock_in;
    logic rst_in;
    logic [N-1:0] en;
    logic [N-1:0][2:0] mode;
    logic [N-1:0][2:0] sel;
    logic [N-1:0][1:0] ccs;
    logic [N-1:0][3:0] edges;
    logic [N-1:0] cse;
    logic [N-1:0] oclr;
    logic [N-1:0] pin0;
    logic [N-1:0] pin1;
    logic [N-1:0][15:0] cnt;
    logic [N-1:0][15:0] reg0;
    logic [N-1:0][15:0] reg1;
    logic [N-1:0] flag;
    logic go;
    logic [7:0] hi_len;
    logic [7:0] lo_len;
    logic [3:0] periods;
    logic src_pin;
    logic src_busy;
    int bad_count;
    int checks_done;

    pwc_capture_top #(.NUM_UNITS(N)) dut (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .count_enable_bit_in(en),
        .operating_mode_field_in(mode),
        .clock_select_in(sel),
        .capture_select_in(ccs),
        .edge_select_in(edges),
        .cascade_slave_select_in(cse),
        .overflow_clear_in(oclr),
        .capture_input_zero_in({pin0[N-1:1], src_pin}),
        .capture_input_one_in({pin1[N-1:1], src_pin}),
        .counter_value_out(cnt),
        .capture_register_zero_out(reg0),
        .capture_register_one_out(reg1),
        .overflow_flag_out(flag),
        .overflow_interrupt_out(),
        .capture_interrupt_zero_out(),
        .capture_interrupt_one_out()
    );

    pwc_pulse_src src (
        .clock_in(clock_in),
        .go_in(go),
        .high_len_in(hi_len),
        .low_len_in(lo_len),
        .periods_in(periods),
        .pin_out(src_pin),
        .busy_out(src_busy)
    );

    // free-running 125 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        rst_in = 1'b1;
        {en, mode, sel, ccs, edges, cse, oclr, pin0, pin1} = '0;
        step(6);
        rst_in = 1'b0;
    endtask

    // one burst from the pulse source, waited for under a bound
    task automatic burst(input logic [7:0] h, input logic [7:0] l, input logic [3:0] p);
        int i;
        hi_len = h;
        lo_len = l;
        periods = p;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (i = 0; i < 2000 && src_busy; i++) step(1);
    endtask

    task automatic t_start();
        do_reset();
        mode[0] = 3'h6;
        en[0] = 1'b1;
        step(10);
        check(cnt[0], 16'h0008);
        en[0] = 1'b0;
        step(5);
        check(cnt[0], 16'h0008);
        edges[0] = 4'h1;
        en[0] = 1'b1;
        burst(8'h04, 8'h04, 4'h1);
        check({15'h0, reg0[0] === 16'hffff || reg0[0] === 16'h0000}, 16'h0001);
        $display("start test done");
    endtask

    task automatic t_edges(input logic [3:0] f, input logic [15:0] e0, input logic [15:0] e1);
        do_reset();
        // internal count clock is the only source here
        mode[0] = 3'h6;
        edges[0] = f;
        en[0] = 1'b1;
        step(3);
        burst(8'h05, 8'h09, 4'h3);
        check(reg0[0], e0);
        check(reg1[0], e1);
        en[0] = 1'b0;
        burst(8'h02, 8'h02, 4'h2);
        check(reg0[0], e0);
        check(reg1[0], e1);
        $display("edge test %h done", f);
    endtask

    task automatic t_cascade();
        do_reset();
        // free-running halves, both registers capturing, slave selected
        mode = {3'h6, 3'h5, 3'h6, 3'h5, 3'h5};
        ccs = {2'h0, 2'h0, 2'h0, 2'h3, 2'h3};
        cse = 5'b10010;
        edges = {4'h0, 4'h0, 4'h0, 4'hf, 4'h1};
        step(1);
        en = 5'b10101;
        step(4);
        pin0[1] = 1'b1;
        pin1[1] = 1'b1;
        step(4);
        pin0[1] = 1'b0;
        pin1[1] = 1'b0;
        step(65532);
        check(cnt[0], 16'h0002);
        check(cnt[1], 16'h0001);
        check(cnt[2], 16'h0002);
        check(cnt[4], 16'h0002);
        check({15'h0, flag[2]}, 16'h0001);
        burst(8'h03, 8'h03, 4'h1);
        // upper halves read only after the capture, with no further capture pending
        check(reg0[1], 16'h0001);
        check(reg1[1], 16'h0000);
        check({15'h0, flag[0]}, 16'h0001);
        oclr[2] = 1'b1;
        step(1);
        oclr[2] = 1'b0;
        step(1);
        check({15'h0, flag[2]}, 16'h0000);
        check({15'h0, flag[4]}, 16'h0001);
        $display("cascade test done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        bad_count = 0;
        checks_done = 0;
        go = 1'b0;
        hi_len = 8'h00;
        lo_len = 8'h00;
        periods = 4'h0;
        do_reset();
        t_start();
        t_edges(4'h1, 16'h000d, 16'h0000);
        t_edges(4'h2, 16'h000d, 16'h0000);
        t_edges(4'h3, 16'h0004, 16'h0000);
        t_edges(4'h9, 16'h0008, 16'h0004);
        t_edges(4'hc, 16'h0000, 16'h0004);
        t_cascade();
        tally_and_finish();
    end

    // watchdog well beyond the expected run length
    initial begin
        #(8 * 90000);
        bad_count++;
        tally_and_finish();
    end
endmodule
